// ===== scm_defines.svh
// scm_defines.svh: offsets, field positions, reset values and timing counts
// of the multiprocessor serial channel; assumes inclusion by bare name
`ifndef SCM_DEFINES_SVH
`define SCM_DEFINES_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define SCM_CLK_MHZ     100
`define SCM_BIT_NS      160
`define SCM_BIT_CYC     ((`SCM_BIT_NS * `SCM_CLK_MHZ) / 1000)
`define SCM_HALF_CYC    (`SCM_BIT_CYC / 2)

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SCM_OFS_CTRL    12'h000
`define SCM_OFS_STAT    12'h004
`define SCM_OFS_TXD     12'h008
`define SCM_OFS_RXD     12'h00C

// ----------------------------------------
// control register fields
// ----------------------------------------
`define SCM_C_RXEN      0
`define SCM_C_TXEN      1
`define SCM_C_RIE       2
`define SCM_C_TIE       3
`define SCM_C_TX_END_IRQ_ENABLE      4
`define SCM_C_IDRE      5
`define SCM_C_LEN7      8
`define SCM_C_PAREN     9
`define SCM_C_PARODD    10
`define SCM_C_MPEN      11
`define SCM_C_STOP2     12
`define SCM_CTRL_RST    13'h0000

// ----------------------------------------
// status register fields
// ----------------------------------------
`define SCM_S_TXEMPTY   0
`define SCM_S_RXFULL    1
`define SCM_S_OVR       2
`define SCM_S_FRM       3
`define SCM_S_PAR       4
`define SCM_S_TXEND     5
`define SCM_S_IDBIT     6
`define SCM_S_IDBT      7
`define SCM_S_PIN       8

`endif

// ===== scm_link_if.sv
// scm_link_if.sv: serial line between the channel and the far processor
// assumes the bench joins both ends through this interface
`timescale 1ns/1ps
`default_nettype none

interface scm_link_if;
  logic dev_txd;   // channel to far end
  logic peer_txd;  // far end to channel

  modport dev  (output dev_txd, input peer_txd);
  modport peer (input dev_txd, output peer_txd);
endinterface : scm_link_if

`default_nettype wire

// ===== scm_peer.sv
// scm_peer.sv: far processor on the shared line, sends and receives
// id-bit frames; its software does id compare and error handling
`timescale 1ns/1ps
`default_nettype none
`include "scm_defines.svh"

module scm_peer (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // format
  input  wire logic        len7,
  input  wire logic        two_stop,
  // send side
  input  wire logic        send_valid,
  output logic             send_ready,
  input  wire logic [7:0]  send_data,
  input  wire logic        send_id,
  // receive side
  output logic             recv_valid,
  output logic [7:0]       recv_data,
  output logic             recv_id,
  output logic             recv_err,
  // serial line
  scm_link_if.peer         link
);

  scm_pkg::scm_fmt_t      fmt;
  scm_pkg::scm_tx_state_t state_r;
  logic [11:0]            frame_r;
  logic [3:0]             left_r;
  logic [7:0]             cnt_r;
  logic                   bit_end;

  // ----------------------------------------
  // id-bit format, parity off
  // ----------------------------------------
  assign fmt          = {len7, 1'b0, 1'b0, 1'b1, two_stop}; // len7, par_en, par_odd, mp_en, two_stop
  assign bit_end      = (cnt_r == 8'(`SCM_BIT_CYC - 1));
  assign send_ready   = (state_r == scm_pkg::TX_IDLE);
  assign link.peer_txd = frame_r[0];

  // id flag chosen with the data before the send starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= scm_pkg::TX_IDLE;
      frame_r <= 12'hFFF;
      left_r  <= 4'h0;
      cnt_r   <= 8'h00;
    end else if (send_valid && send_ready) begin
      state_r <= scm_pkg::TX_SEND;
      frame_r <= scm_pkg::scm_frame(len7 ? {1'b0, send_data[6:0]} : send_data, fmt, send_id);
      left_r  <= scm_pkg::scm_frame_len(fmt);
      cnt_r   <= 8'h00;
    end else if (state_r == scm_pkg::TX_SEND) begin
      cnt_r <= bit_end ? 8'h00 : cnt_r + 8'h01;
      if (bit_end) begin
        frame_r <= {1'b1, frame_r[11:1]};
        left_r  <= left_r - 4'h1;
        if (left_r == 4'h1) state_r <= scm_pkg::TX_IDLE;
      end
    end
  end

  // receiver, always on
  scm_rx_frame u_rx (
    .pclk     (pclk),
    .presetn  (presetn),
    .rxd      (link.dev_txd),
    .rx_go    (1'b1),
    .fmt      (fmt),
    .line_lvl (),
    .done     (recv_valid),
    .data     (recv_data),
    .ext      (recv_id),
    .par_err  (),
    .frm_err  (recv_err)
  );

endmodule : scm_peer

`default_nettype wire

// ===== scm_pkg.sv
// scm_pkg.sv: types and frame helpers of the multiprocessor serial channel
// assumes nothing beyond a SystemVerilog compiler
package scm_pkg;

  // frame format selection
  typedef struct packed {
    logic len7;
    logic par_en;
    logic par_odd;
    logic mp_en;
    logic two_stop;
  } scm_fmt_t;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} scm_rx_state_t;
  typedef enum logic       {TX_IDLE, TX_SEND}           scm_tx_state_t;

  // extra bit present (parity or id bit)
  function automatic logic scm_ext_en(input scm_fmt_t f);
    return f.mp_en | f.par_en;
  endfunction : scm_ext_en

  // line image of a frame, bit 0 first; unused upper bits are stop/marking ones
  function automatic logic [11:0] scm_frame(input logic [7:0] d, input scm_fmt_t f, input logic ext);
    logic [11:0] fr;
    fr = 12'hFFF;
    fr[0] = 1'b0;
    fr[8:1] = d;
    if (f.len7) fr[8] = 1'b1;
    if (scm_ext_en(f)) begin
      if (f.len7) fr[8] = ext;
      else fr[9] = ext;
    end
    return fr;
  endfunction : scm_frame

  // bits in a frame including start and stops
  function automatic logic [3:0] scm_frame_len(input scm_fmt_t f);
    return 4'h1 + (f.len7 ? 4'h7 : 4'h8) + {3'h0, scm_ext_en(f)} + (f.two_stop ? 4'h2 : 4'h1);
  endfunction : scm_frame_len

endpackage : scm_pkg

// ===== scm_rx_frame.sv
// scm_rx_frame.sv: frame receiver with 16x bit timing and checks
// assumes an asynchronous serial input and the scm format struct
`timescale 1ns/1ps
`default_nettype none
`include "scm_defines.svh"

module scm_rx_frame (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // line and control
  input  wire logic             rxd,
  input  wire logic             rx_go,
  input  wire scm_pkg::scm_fmt_t fmt,
  // results
  output logic                  line_lvl,
  output logic                  done,
  output logic [7:0]            data,
  output logic                  ext,
  output logic                  par_err,
  output logic                  frm_err
);

  logic                   sync1_r;
  logic                   sync2_r;
  scm_pkg::scm_rx_state_t state_r;
  logic [7:0]             cnt_r;
  logic [3:0]             idx_r;
  logic [9:0]             bits_r;
  logic [9:0]             bits_w;
  logic [3:0]             last_w;
  logic [7:0]             d_w;
  logic                   e_w;
  logic                   bit_end;

  // ----------------------------------------
  // decode of the sampled frame
  // ----------------------------------------
  assign last_w  = (fmt.len7 ? 4'h7 : 4'h8) + {3'h0, scm_pkg::scm_ext_en(fmt)};
  assign bit_end = (cnt_r == 8'(`SCM_BIT_CYC - 1));
  assign line_lvl = sync2_r;

  // current bit merged into collected bits
  always_comb begin
    bits_w = bits_r;
    bits_w[idx_r] = sync2_r;
  end

  assign d_w = fmt.len7 ? {1'b0, bits_w[6:0]} : bits_w[7:0];
  assign e_w = fmt.len7 ? bits_w[7] : bits_w[8];

  // two-flop synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end else begin
      sync1_r <= rxd;
      sync2_r <= sync1_r;
    end
  end

  // start detect, mid-bit sampling, end-of-frame checks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= scm_pkg::RX_IDLE;
      cnt_r   <= 8'h00;
      idx_r   <= 4'h0;
      bits_r  <= 10'h000;
      done    <= 1'b0;
      data    <= 8'h00;
      ext     <= 1'b0;
      par_err <= 1'b0;
      frm_err <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_r)
        scm_pkg::RX_IDLE: begin
          cnt_r <= 8'h00;
          if (rx_go && !sync2_r) state_r <= scm_pkg::RX_START;
        end
        scm_pkg::RX_START: begin
          if (!rx_go) begin
            state_r <= scm_pkg::RX_IDLE;
          end else if (cnt_r == 8'(`SCM_HALF_CYC - 1)) begin
            cnt_r   <= 8'h00;
            idx_r   <= 4'h0;
            state_r <= sync2_r ? scm_pkg::RX_IDLE : scm_pkg::RX_BITS;
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        scm_pkg::RX_BITS: begin
          if (!rx_go) begin
            state_r <= scm_pkg::RX_IDLE;
          end else if (bit_end) begin
            cnt_r  <= 8'h00;
            bits_r <= bits_w;
            idx_r  <= idx_r + 4'h1;
            if (idx_r == last_w) begin
              // only the first stop bit is looked at
              state_r <= scm_pkg::RX_IDLE;
              done    <= 1'b1;
              data    <= d_w;
              ext     <= e_w;
              frm_err <= ~sync2_r;
              par_err <= fmt.par_en & ~fmt.mp_en & ((^d_w ^ e_w) != fmt.par_odd);
            end
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        default: state_r <= scm_pkg::RX_IDLE;
      endcase
    end
  end

endmodule : scm_rx_frame

`default_nettype wire

// ===== scm_serial_channel.sv
// scm_serial_channel.sv: serial channel with receive checks, id-bit addressing
// and id-bit transmit, registers on APB
// assumes one pclk domain, the far end on scm_link_if, dma acks on pclk
//
// Contract
// - start bit 0 starts bit timing, receive
// - data shifted in least significant bit first
// - parity check against even/odd setting
// - first stop bit must be 1
// - copy only when receive-full flag is 0
// - good frame stored, receive-full set
// - frame while full sets overrun, no copy
// - stop 0 or parity bad: flag, copy
// - error flag blocks reception and receive-full
// - receive-full raises interrupt when enabled
// - any error flag raises error interrupt; here only while RIE is set
// - reader clears receive-full before next stop
// - dma read clears receive-full automatically
// - software clears error flags to restart
// - serial input level readable by software
// - id format ignores parity settings
// - start, data lsb first, id bit, stops
// - empty cleared: load, set empty, send, interrupt
// - at stop sample empty; continue or end
// - software writes data, id bit, then clears
// - armed id cycle skips frames with bit 0
// - software compares id, re-arms on mismatch
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "scm_defines.svh"

module scm_serial_channel (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // dma
  input  wire logic        dma_rd,
  output logic [7:0]       dma_rdata,
  // interrupt requests
  output logic             rx_full_irq,
  output logic             rx_error_irq,
  output logic             tx_empty_irq,
  output logic             tx_end_irq,
  // serial line
  scm_link_if.dev          link
);

  logic [12:0]            serial_control_reg_r;
  logic [7:0]             tx_data_reg_r;
  logic [7:0]             rx_data_reg_r;
  logic                   tx_empty_flag_r;
  logic                   rx_full_flag_r;
  logic                   overrun_flag_r;
  logic                   framing_err_flag_r;
  logic                   parity_err_flag_r;
  logic                   tx_end_flag_r;
  logic                   id_bit_r;
  logic                   id_bit_transfer_r;
  scm_pkg::scm_tx_state_t tx_state_r;
  logic [11:0]            tx_shift_reg_r;
  logic [3:0]             tx_left_r;
  logic [7:0]             tx_cnt_r;
  logic                   rx_done;
  logic [7:0]             rx_data;
  logic                   rx_ext;
  logic                   rx_perr;
  logic                   rx_ferr;
  logic                   rx_pin;

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  scm_pkg::scm_fmt_t fmt;
  logic setup_rd, wr, hit_ctrl, hit_stat, hit_txd, hit_rxd, mapped;
  logic wr_ctrl, wr_stat, wr_txd;
  logic err_any, rx_go, rx_skip, rx_acc, rx_copy, full_set, ovr_set;
  logic clr_full, clr_ovr, clr_frm, clr_par, clr_empty;
  logic tx_load, tx_bit_end, tx_ext, stop_start;
  logic [7:0] tx_d;
  logic [31:0] stat_w;

  // format fields in struct order, len7 first, one driver for the whole struct
  assign fmt = {serial_control_reg_r[`SCM_C_LEN7], serial_control_reg_r[`SCM_C_PAREN],
                serial_control_reg_r[`SCM_C_PARODD], serial_control_reg_r[`SCM_C_MPEN],
                serial_control_reg_r[`SCM_C_STOP2]};

  assign hit_ctrl = (paddr == `SCM_OFS_CTRL);
  assign hit_stat = (paddr == `SCM_OFS_STAT);
  assign hit_txd  = (paddr == `SCM_OFS_TXD);
  assign hit_rxd  = (paddr == `SCM_OFS_RXD);
  assign mapped   = hit_ctrl | hit_stat | hit_txd | hit_rxd;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign wr       = psel & penable & pwrite;
  assign wr_ctrl  = wr & hit_ctrl;
  assign wr_stat  = wr & hit_stat;
  assign wr_txd   = wr & hit_txd;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;

  // receive, error and empty flags clear on a written 0; the end flag does not
  assign clr_full  = (wr_stat & ~pwdata[`SCM_S_RXFULL]) | dma_rd;
  assign clr_ovr   = wr_stat & ~pwdata[`SCM_S_OVR];
  assign clr_frm   = wr_stat & ~pwdata[`SCM_S_FRM];
  assign clr_par   = wr_stat & ~pwdata[`SCM_S_PAR];
  assign clr_empty = wr_stat & ~pwdata[`SCM_S_TXEMPTY];

  assign stat_w = {23'h000000, rx_pin, id_bit_transfer_r, id_bit_r, tx_end_flag_r, parity_err_flag_r,
                   framing_err_flag_r, overrun_flag_r, rx_full_flag_r, tx_empty_flag_r};

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h00000000;
    else if (setup_rd) prdata <= hit_ctrl ? {19'h00000, serial_control_reg_r} :
                                 hit_stat ? stat_w :
                                 hit_txd  ? {24'h000000, tx_data_reg_r} :
                                 hit_rxd  ? {24'h000000, rx_data_reg_r} : 32'h00000000;
  end

  // ----------------------------------------
  // receive path
  // ----------------------------------------
  assign err_any  = overrun_flag_r | framing_err_flag_r | parity_err_flag_r;
  assign rx_go    = serial_control_reg_r[`SCM_C_RXEN] & ~err_any;
  assign rx_skip  = fmt.mp_en & serial_control_reg_r[`SCM_C_IDRE] & ~rx_ext;
  assign rx_acc   = rx_done & ~err_any & ~rx_skip;
  assign rx_copy  = rx_acc & ~rx_full_flag_r;
  assign ovr_set  = rx_acc & rx_full_flag_r;
  assign full_set = rx_copy & ~rx_perr & ~rx_ferr;

  scm_rx_frame u_rx (
    .pclk     (pclk),
    .presetn  (presetn),
    .rxd      (link.peer_txd),
    .rx_go    (rx_go),
    .fmt      (fmt),
    .line_lvl (rx_pin),
    .done     (rx_done),
    .data     (rx_data),
    .ext      (rx_ext),
    .par_err  (rx_perr),
    .frm_err  (rx_ferr)
  );

  // receive data and id bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_reg_r <= 8'h00;
      id_bit_r      <= 1'b0;
    end else if (rx_copy) begin
      rx_data_reg_r <= rx_data;
      id_bit_r      <= rx_ext;
    end
  end

  // receive flags, hardware set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_full_flag_r     <= 1'b0;
      overrun_flag_r     <= 1'b0;
      framing_err_flag_r <= 1'b0;
      parity_err_flag_r  <= 1'b0;
    end else begin
      rx_full_flag_r     <= full_set | (rx_full_flag_r & ~clr_full);
      overrun_flag_r     <= ovr_set | (overrun_flag_r & ~clr_ovr);
      framing_err_flag_r <= (rx_copy & rx_ferr) | (framing_err_flag_r & ~clr_frm);
      parity_err_flag_r  <= (rx_copy & rx_perr) | (parity_err_flag_r & ~clr_par);
    end
  end

  // ----------------------------------------
  // control and transmit data registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_control_reg_r <= `SCM_CTRL_RST;
      tx_data_reg_r        <= 8'h00;
      id_bit_transfer_r    <= 1'b0;
    end else begin
      if (wr_ctrl) serial_control_reg_r <= pwdata[12:0];
      else if (rx_acc && fmt.mp_en && rx_ext) serial_control_reg_r[`SCM_C_IDRE] <= 1'b0;
      if (wr_txd) tx_data_reg_r <= pwdata[7:0];
      if (wr_stat) id_bit_transfer_r <= pwdata[`SCM_S_IDBT];
    end
  end

  // ----------------------------------------
  // transmit path
  // ----------------------------------------
  assign tx_load    = serial_control_reg_r[`SCM_C_TXEN] & (tx_state_r == scm_pkg::TX_IDLE) & ~tx_empty_flag_r;
  assign tx_bit_end = (tx_cnt_r == 8'(`SCM_BIT_CYC - 1));
  assign tx_d       = fmt.len7 ? {1'b0, tx_data_reg_r[6:0]} : tx_data_reg_r;
  assign tx_ext     = fmt.mp_en ? id_bit_transfer_r : (^tx_d ^ fmt.par_odd);
  assign stop_start = tx_bit_end & (tx_left_r == (fmt.two_stop ? 4'h3 : 4'h2));

  // empty and end flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_empty_flag_r <= 1'b1;
      tx_end_flag_r   <= 1'b1;
    end else if (!serial_control_reg_r[`SCM_C_TXEN]) begin
      tx_empty_flag_r <= 1'b1;
      tx_end_flag_r   <= 1'b1;
    end else begin
      tx_empty_flag_r <= tx_load | (tx_empty_flag_r & ~clr_empty);
      if (tx_load) tx_end_flag_r <= 1'b0;
      else if (stop_start && tx_empty_flag_r) tx_end_flag_r <= 1'b1;
    end
  end

  // frame shifter; next frame loads from idle right after the stops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_r     <= scm_pkg::TX_IDLE;
      tx_shift_reg_r <= 12'hFFF;
      tx_left_r      <= 4'h0;
      tx_cnt_r       <= 8'h00;
    end else if (!serial_control_reg_r[`SCM_C_TXEN]) begin
      tx_state_r     <= scm_pkg::TX_IDLE;
      tx_shift_reg_r <= 12'hFFF;
    end else if (tx_load) begin
      tx_state_r     <= scm_pkg::TX_SEND;
      tx_shift_reg_r <= scm_pkg::scm_frame(tx_d, fmt, tx_ext);
      tx_left_r      <= scm_pkg::scm_frame_len(fmt);
      tx_cnt_r       <= 8'h00;
    end else if (tx_state_r == scm_pkg::TX_SEND) begin
      tx_cnt_r <= tx_bit_end ? 8'h00 : tx_cnt_r + 8'h01;
      if (tx_bit_end) begin
        tx_shift_reg_r <= {1'b1, tx_shift_reg_r[11:1]};
        tx_left_r      <= tx_left_r - 4'h1;
        if (tx_left_r == 4'h1) tx_state_r <= scm_pkg::TX_IDLE;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign link.dev_txd = tx_shift_reg_r[0];                                  // marking is all ones
  assign dma_rdata    = rx_data_reg_r;
  assign rx_full_irq  = serial_control_reg_r[`SCM_C_RIE] & rx_full_flag_r;
  assign rx_error_irq = serial_control_reg_r[`SCM_C_RIE] & err_any;
  assign tx_empty_irq = serial_control_reg_r[`SCM_C_TIE] & tx_empty_flag_r;
  assign tx_end_irq   = serial_control_reg_r[`SCM_C_TX_END_IRQ_ENABLE] & tx_end_flag_r;

endmodule : scm_serial_channel

`default_nettype wire

// ===== scm_serial_channel_asserts.sv
// scm_serial_channel_asserts.sv: line timing and interrupt checks of the channel
// assumes pclk domain signals handed in by the bench top, link idle high
`timescale 1ns/1ps
`default_nettype none

module scm_serial_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // line and bus
  input wire logic dev_txd,
  input wire logic peer_txd,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic dma_rd,
  // interrupts
  input wire logic rx_full_irq,
  input wire logic rx_error_irq,
  input wire logic tx_end_irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // line timing
  // ----------------------------------------
  a_dev_start_low: assert property ($fell(dev_txd) |-> (!dev_txd)[*8] ##1 (!dev_txd)[*8])
    else $error("start bit shorter than a bit period");
  a_dev_bit_hold: assert property ($changed(dev_txd) |=> $stable(dev_txd)[*8])
    else $error("device line bit too short");
  a_peer_bit_hold: assert property ($changed(peer_txd) |=> $stable(peer_txd)[*8])
    else $error("peer line bit too short");
  a_end_line_mark: assert property (tx_end_irq |-> dev_txd)
    else $error("line not marking after transmit end");
  // ----------------------------------------
  // receive flags
  // ----------------------------------------
  a_err_irq_fall: assert property ($fell(rx_error_irq) |-> $past(psel && penable && pwrite))
    else $error("error flag cleared without a write");
  a_full_irq_fall: assert property ($fell(rx_full_irq) |-> $past(dma_rd || (psel && penable && pwrite)))
    else $error("receive full cleared without read or write");
  a_full_while_err: assert property ($rose(rx_full_irq) |-> !$past(rx_error_irq))
    else $error("receive full set while an error flag stands");
  a_full_at_stop: assert property ($rose(rx_full_irq) |-> peer_txd)
    else $error("receive full set outside a stop bit");
  // main scenarios
  c_rx_full: cover property ($rose(rx_full_irq));
  c_rx_err: cover property ($rose(rx_error_irq));
  c_tx_frame: cover property ($fell(dev_txd));
endmodule : scm_serial_asserts

`default_nettype wire

// ===== scm_serial_channel_tb.sv
// scm_serial_channel_tb.sv: channel and far processor joined on one link
// assumes the design files and scm_defines.svh are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "scm_defines.svh"

module scm_serial_channel_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        dma_rd = 1'b0;
  logic        send_valid = 1'b0;
  logic        send_id = 1'b0;
  logic [7:0]  send_data = 8'h00;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic [7:0]  dma_rdata, recv_data;
  logic        pready, pslverr, err, send_ready, recv_valid, recv_id, recv_err;
  logic        rx_full_irq, rx_error_irq, tx_empty_irq, tx_end_irq;
  int          fail_count = 0;
  int          num_checks = 0;

  scm_link_if link ();
  scm_serial_channel u_scm_serial_channel (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .dma_rd(dma_rd), .dma_rdata(dma_rdata), .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq),
    .tx_empty_irq(tx_empty_irq), .tx_end_irq(tx_end_irq), .link(link.dev));
  scm_peer u_scm_peer (.pclk(pclk), .presetn(presetn), .len7(1'b0), .two_stop(1'b0), .send_valid(send_valid),
    .send_ready(send_ready), .send_data(send_data), .send_id(send_id), .recv_valid(recv_valid),
    .recv_data(recv_data), .recv_id(recv_id), .recv_err(recv_err), .link(link.peer));
  scm_serial_asserts u_scm_serial_asserts (.pclk(pclk), .presetn(presetn), .dev_txd(link.dev_txd),
    .peer_txd(link.peer_txd), .psel(psel), .penable(penable), .pwrite(pwrite), .dma_rd(dma_rd),
    .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq), .tx_end_irq(tx_end_irq));

  // 100 MHz clock
  always #5 pclk = ~pclk;

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    chk(i < 50, 1'b1);
    if (i >= 50) results();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // far end sends one frame and returns once the line is idle
  task automatic pk(input logic [7:0] d, input logic id);
    int i;
    @(posedge pclk);
    send_valid <= 1'b1;
    send_data <= d;
    send_id <= id;
    @(posedge pclk);
    send_valid <= 1'b0;
    for (i = 0; i < 400; i++) begin
      @(posedge pclk);
      if (send_ready === 1'b1) break;
    end
    chk(i < 400, 1'b1);
    if (i >= 400) results();
    repeat (20) @(posedge pclk);
  endtask : pk

  // wait for a frame at the far end
  task automatic wv();
    int i;
    for (i = 0; i < 600; i++) begin
      @(posedge pclk);
      if (recv_valid === 1'b1) break;
    end
    chk(i < 600, 1'b1);
    if (i >= 600) results();
  endtask : wv

  // reset values and an unmapped place
  task automatic t_reset();
    apb(1'b0, `SCM_OFS_STAT, 32'h0);
    chk(rd, 32'h0000_0121);
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    apb(1'b0, 12'h010, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
  endtask : t_reset

  // id addressing, overrun, dma read, error blocking and restart
  task automatic t_rx();
    apb(1'b1, `SCM_OFS_CTRL, 32'h0000_0A25);
    pk(8'h42, 1'b1);
    chk(rx_full_irq, 1'b1);
    apb(1'b1, `SCM_OFS_CTRL, 32'h0000_0A25);
    apb(1'b1, `SCM_OFS_STAT, 32'h0);
    pk(8'h3C, 1'b0);
    chk(rx_full_irq, 1'b0);
    pk(8'hA5, 1'b1);
    chk(rx_full_irq, 1'b1);
    apb(1'b0, `SCM_OFS_RXD, 32'h0);
    chk(rd, 32'h0000_00A5);
    apb(1'b0, `SCM_OFS_STAT, 32'h0);
    chk(rd, 32'h0000_0163);
    apb(1'b0, `SCM_OFS_CTRL, 32'h0);
    chk(rd, 32'h0000_0A05);
    pk(8'h5A, 1'b0);
    apb(1'b0, `SCM_OFS_STAT, 32'h0);
    chk(rd[4:0], 5'h07);
    chk(rx_error_irq, 1'b1);
    chk(dma_rdata, 8'hA5);
    @(posedge pclk);
    dma_rd <= 1'b1;
    @(posedge pclk);
    dma_rd <= 1'b0;
    apb(1'b0, `SCM_OFS_STAT, 32'h0);
    chk(rd[4:0], 5'h05);
    pk(8'h11, 1'b0);
    apb(1'b0, `SCM_OFS_STAT, 32'h0);
    chk(rd[4:0], 5'h05);
    apb(1'b1, `SCM_OFS_STAT, 32'h0);
    pk(8'h77, 1'b0);
    apb(1'b0, `SCM_OFS_RXD, 32'h0);
    chk(rd, 32'h0000_0077);
    chk(rx_error_irq, 1'b0);
    apb(1'b1, `SCM_OFS_STAT, 32'h0);
    apb(1'b1, `SCM_OFS_CTRL, 32'h0000_0201);
    pk(8'h01, 1'b0); // extra bit 0 read as even parity
    apb(1'b0, `SCM_OFS_STAT, 32'h0);
    chk(rd[4:0], 5'h11);
    chk(dma_rdata, 8'h01);
    apb(1'b1, `SCM_OFS_STAT, 32'h0);
    apb(1'b1, `SCM_OFS_CTRL, 32'h0000_0001);
    pk(8'h02, 1'b0); // extra bit 0 read as first stop
    apb(1'b0, `SCM_OFS_STAT, 32'h0);
    chk(rd[4:0], 5'h09);
    chk(dma_rdata, 8'h02);
  endtask : t_rx

  // two frames back to back, id then data, parity setting on
  task automatic t_tx();
    apb(1'b1, `SCM_OFS_CTRL, 32'h0000_0A1A);
    apb(1'b1, `SCM_OFS_TXD, 32'h0000_00C3);
    apb(1'b1, `SCM_OFS_STAT, 32'h0000_0080);
    apb(1'b1, `SCM_OFS_TXD, 32'h0000_0096);
    chk(tx_empty_irq, 1'b1);
    chk(tx_end_irq, 1'b0);
    apb(1'b1, `SCM_OFS_STAT, 32'h0);
    wv();
    chk({recv_err, recv_id, recv_data}, 32'h0000_01C3);
    wv();
    chk({recv_err, recv_id, recv_data}, 32'h0000_0096);
    chk(tx_end_irq, 1'b1);
  endtask : t_tx

  // verdict
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  // main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rx();
    t_tx();
    results();
  end
endmodule : scm_serial_channel_tb

`default_nettype wire
